/* design/uor_flags.sv */
// receive overrun flag and data-ready flag of one uart channel
// Behaviour
// - single mode: unread character overwritten sets overrun
// - line status read clears overrun
// - fifo overrun only when full plus new character
// - overrun flag shows at once
// - overflowing character never enters the fifo
// - overrun set at the stop bit strobe
// - overrun reads zero after reset
// - data ready set when character stored
// - data ready clears once storage emptied
// - data ready reads zero after reset
`timescale 1ns/1ns
`default_nettype none
`include "uor_defines.svh"
module uor_flags #(
    parameter int DATA_W = `UOR_DATA_W,
    parameter int DEPTH  = `UOR_FIFO_DEPTH
) (
    // clock, reset, enable
    input  wire logic              i_clk,
    input  wire logic              i_rst,
    input  wire logic              i_ce,
    // configuration
    input  wire logic              i_fifo_mode,
    // receiver shift logic, strobe at stop bit time
    input  wire logic              i_char_done,
    input  wire logic [DATA_W-1:0] i_char_data,
    // host reads
    input  wire logic              i_lsr_rd,
    input  wire logic              i_rx_rd,
    // status and data to the host
    output logic [`UOR_STAT_W-1:0] o_status,
    output logic [DATA_W-1:0]      o_rx_data,
    output logic                   o_fifo_full
);
    localparam int CNT_W = $clog2(DEPTH + 1);

    uor_pkg::uor_mode_t mode;            // storage mode this cycle
    uor_pkg::uor_mode_t mode_reg;        // mode seen last cycle
    logic [CNT_W-1:0]   count;           // characters held
    logic [DATA_W-1:0]  head;            // oldest character
    logic               flush;           // mode change empties storage
    logic               full;            // storage cannot take more
    logic               pop;             // host takes a character
    logic               push;            // character enters storage
    logic               ovr_event;       // overrun happens this cycle
    logic               ovr_reg;         // sticky overrun flag
    logic               rdy_reg;         // data ready flag
    logic               rdy_next;        // data ready after this cycle

    // notes for the next reader:
    // - every strobe is taken on a rising edge with the enable high;
    //   with the enable low nothing moves, not even the mode history
    // - a change of storage mode empties the storage in that cycle,
    //   so receiver and data-read strobes of that cycle are lost; a
    //   status read still clears the overrun flag there
    // - the overrun flag is not touched by a mode change, so software
    //   still sees an overrun that happened just before the switch
    // - single mode keeps the new character on an overrun, fifo mode
    //   keeps the old ones; that asymmetry is on purpose
    // - a host data read in the same cycle as a character on full
    //   storage makes room, so that case is no overrun at all

    assign mode  = uor_pkg::uor_mode_t'(i_fifo_mode);
    assign flush = (mode != mode_reg);
    assign full  = (mode == uor_pkg::UOR_MODE_FIFO)
                 ? (count == CNT_W'(DEPTH)) : (count != '0);
    // a read of empty storage takes nothing
    assign pop   = i_rx_rd && count != '0 && !flush;

    // overrun: storage full (occupied in single mode) and not being read when the
    // new character completes; the flag is raised at the strobe, so
    // it does not wait for the character to reach the head
    assign ovr_event = i_char_done && !flush && full && !pop;
    // single mode stores even on overrun (overwrite), fifo mode drops
    assign push = i_char_done && !flush
               && !(ovr_event && mode == uor_pkg::UOR_MODE_FIFO);

    // data ready follows occupancy after this cycle's push and pop
    // a flush wins over a push in the same cycle, so the flag falls
    assign rdy_next = !flush && (push || count > CNT_W'(pop));

    // storage of received characters
    uor_rx_store #(
        .DATA_W (DATA_W),
        .DEPTH  (DEPTH)
    ) u_store (
        .i_clk       (i_clk),
        .i_rst       (i_rst),
        .i_ce        (i_ce),
        .i_fifo_mode (i_fifo_mode),
        .i_flush     (flush),
        .i_push      (push),
        .i_pop       (pop),
        .i_data      (i_char_data),
        .o_count     (count),
        .o_head      (head)
    );

    // mode history for flush detection
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            mode_reg <= uor_pkg::UOR_MODE_SINGLE;
        end else if (i_ce) begin
            mode_reg <= mode;
        end
    end

    // sticky overrun: set beats clear so no event is lost
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            ovr_reg <= `UOR_OE_RST;
        end else if (i_ce) begin
            if (ovr_event) begin
                ovr_reg <= 1'b1;
            end else if (i_lsr_rd) begin
                ovr_reg <= 1'b0;
            end
        end
    end

    // data ready register; computed ahead so the flag is registered
    // and the host never sees a combinational glitch on it
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            rdy_reg <= `UOR_RDY_RST;
        end else if (i_ce) begin
            rdy_reg <= rdy_next;
        end
    end

    // registered outputs; data lags the head by one cycle
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_rx_data   <= `UOR_DATA_RST;
            o_fifo_full <= 1'b0;
        end else if (i_ce) begin
            // in the flush cycle the host sees zero instead of the head
            o_rx_data   <= flush ? `UOR_DATA_RST : head;
            o_fifo_full <= (mode == uor_pkg::UOR_MODE_FIFO)
                         && (count == CNT_W'(DEPTH));
        end
    end

    // status bits as the host sees them
    always_comb begin
        o_status                = '0;
        o_status[`UOR_RDY_BIT]  = rdy_reg;
        o_status[`UOR_OE_BIT]   = ovr_reg;
    end

    // checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    // a character arrives while the old one is unread
    sequence s_single_clash;
        i_ce && mode == uor_pkg::UOR_MODE_SINGLE && !flush
        && i_char_done && count != '0 && !pop;
    endsequence
    // a character arrives on a full fifo
    sequence s_fifo_clash;
        i_ce && mode == uor_pkg::UOR_MODE_FIFO && !flush
        && i_char_done && count == CNT_W'(DEPTH) && !pop;
    endsequence
    // the host empties the last character
    sequence s_read_last;
        i_ce && !flush && pop && count == CNT_W'(1) && !push;
    endsequence

    a_single_overrun_set: assert property (
        s_single_clash |=> ovr_reg && rdy_reg && count == CNT_W'(1))
        else $error("single mode overrun not flagged");
    a_lsr_read_clear: assert property (
        i_ce && i_lsr_rd && !ovr_event |=> !ovr_reg)
        else $error("status read did not clear overrun");
    a_fifo_overrun_set: assert property (
        s_fifo_clash |=> ovr_reg)
        else $error("fifo full overrun not flagged");
    a_no_false_overrun: assert property (
        i_ce && !ovr_reg && !ovr_event |=> !ovr_reg)
        else $error("overrun raised without cause");
    a_overrun_immediate: assert property (
        i_ce && ovr_event |=> ovr_reg ##0 o_status[`UOR_OE_BIT])
        else $error("overrun not visible next cycle");
    a_fifo_drop_char: assert property (
        s_fifo_clash |=> count == CNT_W'(DEPTH) && o_fifo_full)
        else $error("overflowing character entered fifo");
    a_stop_strobe_set: assert property (
        i_ce && !ovr_reg ##1 ovr_reg |-> $past(i_char_done))
        else $error("overrun set away from stop bit strobe");
    a_ready_on_store: assert property (
        i_ce && push |=> rdy_reg ##1 (rdy_reg || $past(pop) || !$past(i_ce)
        || $past(flush)))
        else $error("data ready missing after store");
    a_ready_clear_last: assert property (
        s_read_last |=> !rdy_reg)
        else $error("data ready stuck after last read");
    a_ready_holds: assert property (
        i_ce && rdy_reg && !pop && !flush |=> rdy_reg)
        else $error("data ready dropped with data held");
    a_set_beats_read: assert property (
        i_ce && ovr_event && i_lsr_rd |=> ovr_reg)
        else $error("overrun lost against status read");
    a_reset_values: assert property (
        @(posedge i_clk) disable iff (1'b0)
        i_rst |-> o_status == '0)
        else $error("flags not zero in reset");
endmodule // uor_flags
`default_nettype wire

/* design/uor_defines.svh */
// constants for the receive overrun and data-ready flag block
`ifndef UOR_DEFINES_SVH
`define UOR_DEFINES_SVH
`define UOR_DATA_W     8
`define UOR_FIFO_DEPTH 16
`define UOR_RDY_BIT    0
`define UOR_OE_BIT     1
`define UOR_STAT_W     2
`define UOR_OE_RST     1'h0
`define UOR_RDY_RST    1'h0
`define UOR_DATA_RST   8'h00
`endif

/* design/uor_pkg.sv */
// types for the receive overrun and data-ready flag block
package uor_pkg;
    // receive storage mode, chosen by the fifo enable
    typedef enum logic {
        UOR_MODE_SINGLE = 1'b0,
        UOR_MODE_FIFO   = 1'b1
    } uor_mode_t;
endpackage

/* design/uor_rx_store.sv */
// receive storage: holding register in single mode, fifo in fifo mode
`timescale 1ns/1ns
`default_nettype none
`include "uor_defines.svh"
module uor_rx_store #(
    parameter int DATA_W = `UOR_DATA_W,
    parameter int DEPTH  = `UOR_FIFO_DEPTH,
    parameter int CNT_W  = $clog2(DEPTH + 1),
    parameter int PTR_W  = (DEPTH > 1) ? $clog2(DEPTH) : 1
) (
    // clock and control
    input  wire logic              i_clk,
    input  wire logic              i_rst,
    input  wire logic              i_ce,
    input  wire logic              i_fifo_mode,
    input  wire logic              i_flush,
    // write and read strobes
    input  wire logic              i_push,
    input  wire logic              i_pop,
    input  wire logic [DATA_W-1:0] i_data,
    // state
    output logic      [CNT_W-1:0]  o_count,
    output logic      [DATA_W-1:0] o_head
);
    logic [DATA_W-1:0] mem_reg [DEPTH];  // storage flip-flops
    logic [PTR_W-1:0]  wr_reg;           // write index
    logic [PTR_W-1:0]  rd_reg;           // read index
    logic [PTR_W-1:0]  wr_sel;           // slot written this cycle

    // single mode always uses slot zero, so the new character overwrites
    assign wr_sel = i_fifo_mode ? wr_reg : '0;
    assign o_head = mem_reg[i_fifo_mode ? rd_reg : '0];

    // storage entries, one write enable each
    for (genvar g = 0; g < DEPTH; g++) begin : g_entry
        always_ff @(posedge i_clk or posedge i_rst) begin
            if (i_rst) begin
                mem_reg[g] <= '0;
            end else if (i_ce && i_push && wr_sel == PTR_W'(g)) begin
                mem_reg[g] <= i_data;
            end
        end
    end

    // pointers wrap at depth; flush realigns them on a mode change
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            wr_reg <= '0;
            rd_reg <= '0;
        end else if (i_ce) begin
            if (i_flush || !i_fifo_mode) begin
                wr_reg <= '0;
                rd_reg <= '0;
            end else begin
                if (i_push) begin
                    wr_reg <= (wr_reg == PTR_W'(DEPTH - 1)) ? '0 : wr_reg + 1'b1;
                end
                if (i_pop) begin
                    rd_reg <= (rd_reg == PTR_W'(DEPTH - 1)) ? '0 : rd_reg + 1'b1;
                end
            end
        end
    end

    // occupancy; single mode holds at most one character
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_count <= '0;
        end else if (i_ce) begin
            if (i_flush) begin
                o_count <= '0;
            end else if (!i_fifo_mode) begin
                o_count <= (i_push || (o_count != '0 && !i_pop)) ? CNT_W'(1) : '0;
            end else if (i_push && !i_pop) begin
                o_count <= o_count + 1'b1;
            end else if (i_pop && !i_push) begin
                o_count <= o_count - 1'b1;
            end
        end
    end
endmodule // uor_rx_store
`default_nettype wire

/* tb/uor_host.sv */
// host model: random line status and data reads
`timescale 1ns/1ns
`default_nettype none
module uor_host (
    // clock
    input  wire logic       i_clk,
    // directed read requests and random read rate in percent
    input  wire logic       i_lsr_req,
    input  wire logic       i_rx_req,
    input  wire logic [6:0] i_pct,
    // read strobes to the device
    output logic            o_lsr_rd,
    output logic            o_rx_rd
);
    logic rl = 1'b0;  // random status read
    logic rr = 1'b0;  // random data read

    // random picks change just after the edge, so they hold a full cycle
    always begin
        @(posedge i_clk);
        #1;
        rl = ($urandom % 100) < 32'(i_pct);
        rr = ($urandom % 100) < 32'(i_pct);
    end

    // directed requests pass straight through
    assign o_lsr_rd = i_lsr_req | rl;
    assign o_rx_rd  = i_rx_req | rr;
endmodule // uor_host
`default_nettype wire

/* tb/uor_flags_test.sv */
// self-checking bench for the overrun and data-ready flags
`timescale 1ns/1ns
`default_nettype none
module uor_flags_test;
    localparam int DEPTH = 16;
    logic       i_clk = 1'b0, i_rst = 1'b1, i_ce = 1'b1;
    logic       i_fifo_mode = 1'b0, i_char_done = 1'b0;
    logic [7:0] i_char_data = 8'h00;
    logic       lsr_req = 1'b0, rx_req = 1'b0;
    logic [6:0] pct = 7'h00;
    wire logic  i_lsr_rd, i_rx_rd;
    logic [1:0] o_status;
    logic [7:0] o_rx_data, head_prev;
    int         failures = 0, checked = 0;
    logic [7:0] q[$];            // model storage
    logic       oe = 1'b0, mode_prev = 1'b0, had, set;

    uor_flags #(.DATA_W(8), .DEPTH(DEPTH)) u_dut (
        .i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce),
        .i_fifo_mode(i_fifo_mode), .i_char_done(i_char_done),
        .i_char_data(i_char_data), .i_lsr_rd(i_lsr_rd),
        .i_rx_rd(i_rx_rd), .o_status(o_status),
        .o_rx_data(o_rx_data), .o_fifo_full());
    uor_host u_host (
        .i_clk(i_clk), .i_lsr_req(lsr_req), .i_rx_req(rx_req),
        .i_pct(pct), .o_lsr_rd(i_lsr_rd), .o_rx_rd(i_rx_rd));

    // 250 mhz clock
    initial begin
        forever #2 i_clk = ~i_clk;
    end

    task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic results();
        if (failures == 0 && checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // one cycle of receiver and directed host strobes
    task automatic step(logic cd, logic [7:0] d, logic l, logic r);
        @(posedge i_clk);
        #1;
        i_char_done = cd;
        i_char_data = d;
        lsr_req = l;
        rx_req = r;
    endtask

    // reference model, updated from the sampled inputs at each edge
    always @(posedge i_clk) begin
        had = q.size() != 0;
        head_prev = had ? q[0] : 8'h00;
        set = 1'b0;
        if (i_rst) begin
            q.delete();
            oe = 1'b0;
        end else if (i_fifo_mode != mode_prev) begin
            // mode change flushes and ignores that cycle's receiver and data-read strobes
            q.delete();
            mode_prev = i_fifo_mode;
            head_prev = 8'h00;
            if (i_lsr_rd) oe = 1'b0;
        end else begin
            if (i_rx_rd && q.size() != 0) void'(q.pop_front());
            if (i_char_done) begin
                if (!i_fifo_mode && q.size() != 0) begin
                    set = 1'b1;
                    q[0] = i_char_data;
                end else if (q.size() == DEPTH) set = 1'b1;
                else q.push_back(i_char_data);
            end
            // a new overrun beats a same-cycle status read
            if (set) oe = 1'b1;
            else if (i_lsr_rd) oe = 1'b0;
        end
        #2;
        check("data_ready", {7'h00, o_status[0]}, {7'h00, q.size() != 0});
        check("overrun", {7'h00, o_status[1]}, {7'h00, oe});
        if (had && !i_rst) check("rx_data", o_rx_data, head_prev);
    end

    // watchdog well past the expected run length
    initial begin
        #40000;
        failures++;
        results();
    end

    initial begin
        void'($urandom(15636));
        repeat (4) @(posedge i_clk);
        #1;
        i_rst = 1'b0;
        // single mode: overwrite, overrun with same-cycle status read
        step(1'b1, 8'hA1, 1'b0, 1'b0);
        step(1'b0, 8'h00, 1'b0, 1'b0);
        step(1'b1, 8'hB2, 1'b0, 1'b0);
        step(1'b1, 8'hC3, 1'b1, 1'b0);
        step(1'b0, 8'h00, 1'b1, 1'b0);
        step(1'b1, 8'h44, 1'b0, 1'b1);
        step(1'b0, 8'h00, 1'b0, 1'b1);
        step(1'b0, 8'h00, 1'b0, 1'b0);
        // fifo mode: fill past full, clear, pop with char on full, drain
        i_fifo_mode = 1'b1;
        step(1'b0, 8'h00, 1'b0, 1'b0);
        for (int i = 0; i <= DEPTH; i++) step(1'b1, 8'(i + 16), 1'b0, 1'b0);
        step(1'b0, 8'h00, 1'b1, 1'b0);
        step(1'b1, 8'hEE, 1'b0, 1'b1);
        repeat (DEPTH + 2) step(1'b0, 8'h00, 1'b0, 1'b1);
        // random traffic, mode swapped every 500 cycles
        pct = 7'h1E;
        for (int k = 0; k < 2000; k++) begin
            if (k % 500 == 0) i_fifo_mode = ~i_fifo_mode;
            step(($urandom % 3) == 0, 8'($urandom), 1'b0, 1'b0);
        end
        pct = 7'h00;
        repeat (4) step(1'b0, 8'h00, 1'b0, 1'b0);
        results();
    end
endmodule // uor_flags_test
`default_nettype wire
